// ---- pkg/gcsu_pkg.sv ----
// constants and types shared by the gauge control subcommand unit
package gcsu_pkg;

   // ----------------------------------------------------------------
   // command slot codes seen on the link
   // ----------------------------------------------------------------
   localparam logic [7:0] CMD_SLOT_LO = 8'h00;
   localparam logic [7:0] CMD_SLOT_HI = 8'h01;

   // ----------------------------------------------------------------
   // subcommand codes
   // ----------------------------------------------------------------
   localparam logic [15:0] SC_STATE = 16'h0000;
   localparam logic [15:0] SC_PART_TYPE = 16'h0001;
   localparam logic [15:0] SC_CODE_REV = 16'h0002;
   localparam logic [15:0] SC_ECHO = 16'h0007;
   localparam logic [15:0] SC_CELL_PROFILE = 16'h0008;
   localparam logic [15:0] SC_REST_VOLT = 16'h000c;
   localparam logic [15:0] SC_PACK_PRESENT = 16'h000d;
   localparam logic [15:0] SC_PACK_ABSENT = 16'h000e;
   localparam logic [15:0] SC_DEEP_IDLE_SET = 16'h0011;
   localparam logic [15:0] SC_DEEP_IDLE_CLR = 16'h0012;
   localparam logic [15:0] SC_LIGHT_SLEEP_SET = 16'h0013;
   localparam logic [15:0] SC_LIGHT_SLEEP_CLR = 16'h0014;
   localparam logic [15:0] SC_RESTORE = 16'h0015;
   localparam logic [15:0] SC_CFG_REV = 16'h001f;
   localparam logic [15:0] SC_SEAL = 16'h0020;
   localparam logic [15:0] SC_ALGO_START = 16'h0021;
   localparam logic [15:0] SC_FULL_RESET = 16'h0041;
   localparam logic [15:0] SC_ECHO_LIMIT = 16'h0009;

   // ----------------------------------------------------------------
   // gauge state word bit positions
   // ----------------------------------------------------------------
   localparam int BIT_FAS = 14;
   localparam int BIT_SEALED = 13;
   localparam int BIT_CCA = 11;
   localparam int BIT_BCA = 10;
   localparam int BIT_RV_DONE = 9;
   localparam int BIT_RV_FAIL = 8;
   localparam int BIT_INIT = 7;
   localparam int BIT_DEEP_IDLE = 6;
   localparam int BIT_LIGHT_SLEEP = 5;
   localparam int BIT_SLEEP = 4;
   localparam int BIT_CONST_PWR = 3;
   localparam int BIT_RUP_BLOCK = 2;
   localparam int BIT_VOK = 1;
   localparam int BIT_QEN = 0;

   // ----------------------------------------------------------------
   // reset values and identity words (identity values are arbitrary)
   // ----------------------------------------------------------------
   localparam logic [15:0] STATE_WORD_RST = 16'h0000;
   localparam logic SEALED_RST = 1'b0;
   localparam logic [15:0] PART_TYPE_CODE = 16'h1a2b;
   localparam logic [15:0] CODE_REV_CODE = 16'h0101;
   localparam logic [15:0] CELL_PROFILE_CODE = 16'h0202;
   localparam logic [15:0] CFG_REV_CODE = 16'h0000;

   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam longint unsigned SYS_CLK_HZ = 250_000_000;
   localparam longint unsigned TICK_MS = 1000;
   localparam longint unsigned RV_WIN_MS = 165;
   localparam longint unsigned CCA_DELAY_S = 60;
   localparam longint unsigned CCA_RUN_US = 1000;
   localparam longint unsigned TICK_CYC = SYS_CLK_HZ * TICK_MS / 1000;
   localparam longint unsigned RV_WIN_CYC = SYS_CLK_HZ * RV_WIN_MS / 1000;
   localparam longint unsigned CCA_DELAY_CYC = SYS_CLK_HZ * CCA_DELAY_S;
   localparam longint unsigned CCA_RUN_CYC = SYS_CLK_HZ * CCA_RUN_US / 1_000_000;

   // ----------------------------------------------------------------
   // rest-voltage sequencer states
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      RV_IDLE = 3'b001,
      RV_WAIT_TICK = 3'b010,
      RV_PULSE = 3'b100
   } gcsu_rv_e;

endpackage

// ---- src/gcsu_link.sv ----
// link-clock end of the command slot with its clock crossings
`timescale 1ns/1ps
module gcsu_link
   import gcsu_pkg::*;
(
   input wire logic link_clk_i,        // link clock
   input wire logic rst_i,             // system reset, resynchronised here
   input wire logic wr_i,              // byte write strobe
   input wire logic [7:0] addr_i,      // command code
   input wire logic [7:0] wdata_i,     // write byte
   input wire logic [15:0] resp_word_i,// answer word from system side
   input wire logic resp_req_i,        // answer toggle from system side
   output logic [15:0] cmd_word_o,     // assembled subcommand
   output logic cmd_tgl_o,             // toggles per subcommand
   output logic resp_ack_o,            // answer acknowledge toggle
   output logic [7:0] rdata_o          // read byte
);

   logic rst_meta;
   logic lrst;
   logic [7:0] lo_byte_q;
   logic req_meta;
   logic req_sync;
   logic [15:0] resp_hold_q;

   // ----------------------------------------------------------------
   // reset and request synchronisers
   // ----------------------------------------------------------------
   always_ff @(posedge link_clk_i)
   begin
      rst_meta <= rst_i;
      lrst <= rst_meta;
      req_meta <= resp_req_i;
      req_sync <= req_meta;
   end

   // low byte first, word is complete on the high byte
   always_ff @(posedge link_clk_i)
   begin
      if (lrst)
      begin
         lo_byte_q <= 8'h00;
         cmd_word_o <= 16'h0000;
         cmd_tgl_o <= 1'b0;
      end
      else if (wr_i && addr_i == CMD_SLOT_LO)
         lo_byte_q <= wdata_i;
      else if (wr_i && addr_i == CMD_SLOT_HI)
      begin
         cmd_word_o <= {wdata_i, lo_byte_q};
         cmd_tgl_o <= ~cmd_tgl_o;
      end
   end

   // answer word is stable while request and acknowledge differ
   always_ff @(posedge link_clk_i)
   begin
      if (lrst)
      begin
         resp_hold_q <= STATE_WORD_RST;
         resp_ack_o <= 1'b0;
      end
      else if (req_sync != resp_ack_o)
      begin
         resp_hold_q <= resp_word_i;
         resp_ack_o <= req_sync;
      end
   end

   // read back of the slot, other codes read as zero
   always_ff @(posedge link_clk_i)
   begin
      if (lrst)
         rdata_o <= 8'h00;
      else if (addr_i == CMD_SLOT_LO)
         rdata_o <= resp_hold_q[7:0];
      else if (addr_i == CMD_SLOT_HI)
         rdata_o <= resp_hold_q[15:8];
      else
         rdata_o <= 8'h00;
   end

endmodule

// ---- src/gcsu_top.sv ----
// gauge control subcommand unit: decode, state word, modes, rest voltage
`timescale 1ns/1ps
module gcsu_top
   import gcsu_pkg::*;
#(
   parameter longint unsigned TICK_CYC_P = TICK_CYC,
   parameter longint unsigned RV_WIN_CYC_P = RV_WIN_CYC,
   parameter longint unsigned CCA_DELAY_CYC_P = CCA_DELAY_CYC,
   parameter longint unsigned CCA_RUN_CYC_P = CCA_RUN_CYC
)
(
   input wire logic CLK_SYS_I,          // system clock, 250 MHz
   input wire logic RST_I,              // synchronous reset, active high
   input wire logic LINK_CLK_I,         // link clock
   input wire logic LNK_WR_I,           // link byte write strobe
   input wire logic [7:0] LNK_ADDR_I,   // link command code
   input wire logic [7:0] LNK_WDATA_I,  // link write byte
   output logic [7:0] LNK_RDATA_O,      // link read byte
   input wire logic INIT_DONE_I,        // firmware initialisation done
   input wire logic CHARGE_INHIBIT_FLAG_I,          // charge inhibit flag
   input wire logic RV_CUR_BAD_I,       // load current too high in window
   input wire logic INS_DET_EN_I,       // insertion detect enable
   input wire logic TS_PRESENT_I,       // thermistor presence pin
   input wire logic SLEEP_I,            // sleep mode active
   input wire logic DEEP_IDLE_EXIT_I,   // deep idle left, pulse
   input wire logic CONST_POWER_I,      // algorithm in constant power
   input wire logic RES_UPD_BLOCK_I,    // resistance updates disabled
   input wire logic VOLT_UNSUIT_I,      // voltages unsuitable, pulse
   input wire logic BOARD_CAL_I,        // board calibration running
   input wire logic CAL_REQ_I,          // recalibration wanted, pulse
   output logic SOC_INT_O,              // rest-voltage window pulse
   output logic BATTERY_DETECTED_FLAG_O,              // battery detected flag
   output logic DEEP_IDLE_REQ_O,        // deep idle request
   output logic DEEP_IDLE_EXIT_O,       // forced deep idle exit, pulse
   output logic LIGHT_SLEEP_EN_O,       // light sleep enable
   output logic RESTORE_O,              // restore defaults, pulse
   output logic DEV_RESET_O,            // full device reset, pulse
   output logic ALGO_START_O,           // gauging algorithm start, pulse
   output logic SEALED_O                // sealed state
);

   localparam logic [27:0] TICK_LAST = 28'(TICK_CYC_P - 1);
   localparam logic [25:0] RV_LAST = 26'(RV_WIN_CYC_P - 1);
   localparam logic [33:0] CCA_DELAY_LAST = 34'(CCA_DELAY_CYC_P - 1);
   localparam logic [33:0] CCA_RUN_LAST = 34'(CCA_RUN_CYC_P - 1);

   logic [15:0] cmd_word;
   logic cmd_tgl;
   logic resp_ack;
   logic tgl_meta;
   logic tgl_sync;
   logic tgl_seen_q;
   logic ack_meta;
   logic ack_sync;
   logic ts_meta;
   logic ts_sync;
   logic cmd_new;
   logic known;
   logic restricted;
   logic accept;
   logic [15:0] code_q;
   logic go_q;
   logic [15:0] prev_q;
   logic [15:0] echo_q;
   logic [15:0] resp_sel_q;
   logic [15:0] resp_word_q;
   logic resp_req_q;
   logic [15:0] resp_next;
   logic [15:0] state_word;
   logic fas_q;
   logic init_q;
   logic bca_q;
   logic sleep_q;
   logic const_pwr_q;
   logic rup_block_q;
   logic vok_q;
   logic qen_q;
   logic rv_done_q;
   logic rv_fail_q;
   logic [27:0] tick_cnt_q;
   logic tick_q;
   logic [25:0] rv_cnt_q;
   gcsu_rv_e rv_state_q;
   logic init_seen_q;
   logic cca_armed_q;
   logic [33:0] cca_cnt_q;
   logic cca_run_q;

   // ----------------------------------------------------------------
   // link end and crossings
   // ----------------------------------------------------------------
   gcsu_link u_link
   (
      .link_clk_i(LINK_CLK_I),
      .rst_i(RST_I),
      .wr_i(LNK_WR_I),
      .addr_i(LNK_ADDR_I),
      .wdata_i(LNK_WDATA_I),
      .resp_word_i(resp_word_q),
      .resp_req_i(resp_req_q),
      .cmd_word_o(cmd_word),
      .cmd_tgl_o(cmd_tgl),
      .resp_ack_o(resp_ack),
      .rdata_o(LNK_RDATA_O)
   );

   // two-stage synchronisers for link toggles and the presence pin
   always_ff @(posedge CLK_SYS_I)
   begin
      tgl_meta <= cmd_tgl;
      tgl_sync <= tgl_meta;
      ack_meta <= resp_ack;
      ack_sync <= ack_meta;
      ts_meta <= TS_PRESENT_I;
      ts_sync <= ts_meta;
   end

   // edge of the command toggle; word has been stable for two edges
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
         tgl_seen_q <= 1'b0;
      else
         tgl_seen_q <= tgl_sync;
   end

   assign cmd_new = tgl_sync ^ tgl_seen_q;

   // ----------------------------------------------------------------
   // decode and sealing filter
   // ----------------------------------------------------------------
   always_comb
   begin
      unique case (cmd_word)
         SC_STATE, SC_PART_TYPE, SC_CODE_REV, SC_ECHO, SC_CELL_PROFILE,
         SC_REST_VOLT, SC_PACK_PRESENT, SC_PACK_ABSENT, SC_DEEP_IDLE_SET,
         SC_DEEP_IDLE_CLR, SC_LIGHT_SLEEP_SET, SC_LIGHT_SLEEP_CLR,
         SC_RESTORE, SC_CFG_REV, SC_SEAL, SC_ALGO_START, SC_FULL_RESET:
            known = 1'b1;
         default:
            known = 1'b0;
      endcase
      restricted = (cmd_word == SC_RESTORE) || (cmd_word == SC_SEAL) ||
                   (cmd_word == SC_ALGO_START) || (cmd_word == SC_FULL_RESET);
      accept = cmd_new && known && !(SEALED_O && restricted);
   end

   // accepted command held for one cycle so each concern sees it once
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         go_q <= 1'b0;
         code_q <= SC_STATE;
      end
      else
      begin
         go_q <= accept;
         code_q <= accept ? cmd_word : code_q;
      end
   end

   // ----------------------------------------------------------------
   // previous-code echo and answer selection
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         prev_q <= SC_STATE;
         echo_q <= SC_STATE;
         resp_sel_q <= SC_STATE;
      end
      else if (go_q)
      begin
         prev_q <= code_q;
         if (code_q == SC_ECHO)
            echo_q <= (prev_q > SC_ECHO_LIMIT) ? SC_ECHO : prev_q;
         if (code_q == SC_STATE || code_q == SC_PART_TYPE || code_q == SC_CODE_REV ||
             code_q == SC_ECHO || code_q == SC_CELL_PROFILE || code_q == SC_CFG_REV)
            resp_sel_q <= code_q;
      end
   end

   // state word layout, unused and reserved bits read zero
   assign state_word = {1'b0, fas_q, SEALED_O, 1'b0, cca_run_q, bca_q, rv_done_q,
                        rv_fail_q, init_q, DEEP_IDLE_REQ_O, LIGHT_SLEEP_EN_O,
                        sleep_q, const_pwr_q, rup_block_q, vok_q, qen_q};

   always_comb
   begin
      unique case (resp_sel_q)
         SC_PART_TYPE: resp_next = PART_TYPE_CODE;
         SC_CODE_REV: resp_next = CODE_REV_CODE;
         SC_ECHO: resp_next = echo_q;
         SC_CELL_PROFILE: resp_next = CELL_PROFILE_CODE;
         SC_CFG_REV: resp_next = CFG_REV_CODE;
         default: resp_next = state_word;
      endcase
   end

   // answer word is refreshed each time the link end acknowledges
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         resp_word_q <= STATE_WORD_RST;
         resp_req_q <= 1'b0;
      end
      else if (resp_req_q == ack_sync)
      begin
         resp_word_q <= resp_next;
         resp_req_q <= ~resp_req_q;
      end
   end

   // ----------------------------------------------------------------
   // access state
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         SEALED_O <= SEALED_RST;
         fas_q <= SEALED_RST;
      end
      else if (go_q && code_q == SC_SEAL)
      begin
         SEALED_O <= 1'b1;
         fas_q <= 1'b1;
      end
   end

   // one-cycle action pulses
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         RESTORE_O <= 1'b0;
         DEV_RESET_O <= 1'b0;
         ALGO_START_O <= 1'b0;
         DEEP_IDLE_EXIT_O <= 1'b0;
      end
      else
      begin
         RESTORE_O <= go_q && code_q == SC_RESTORE;
         DEV_RESET_O <= go_q && code_q == SC_FULL_RESET;
         ALGO_START_O <= go_q && code_q == SC_ALGO_START;
         DEEP_IDLE_EXIT_O <= go_q && code_q == SC_DEEP_IDLE_CLR;
      end
   end

   // ----------------------------------------------------------------
   // battery presence and init complete
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
         BATTERY_DETECTED_FLAG_O <= 1'b0;
      else if (INS_DET_EN_I)
         BATTERY_DETECTED_FLAG_O <= ts_sync;
      else if (go_q && code_q == SC_PACK_PRESENT)
         BATTERY_DETECTED_FLAG_O <= 1'b1;
      else if (go_q && code_q == SC_PACK_ABSENT)
         BATTERY_DETECTED_FLAG_O <= 1'b0;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
         init_q <= 1'b0;
      else
         init_q <= INIT_DONE_I && BATTERY_DETECTED_FLAG_O;
   end

   // ----------------------------------------------------------------
   // power mode requests
   // ----------------------------------------------------------------
   // set wins over an exit seen in the same cycle
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
         DEEP_IDLE_REQ_O <= 1'b0;
      else if (go_q && code_q == SC_DEEP_IDLE_SET)
         DEEP_IDLE_REQ_O <= 1'b1;
      else if ((go_q && code_q == SC_DEEP_IDLE_CLR) || DEEP_IDLE_EXIT_I)
         DEEP_IDLE_REQ_O <= 1'b0;
   end

   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
         LIGHT_SLEEP_EN_O <= 1'b0;
      else if (go_q && code_q == SC_LIGHT_SLEEP_SET)
         LIGHT_SLEEP_EN_O <= 1'b1;
      else if (go_q && code_q == SC_LIGHT_SLEEP_CLR)
         LIGHT_SLEEP_EN_O <= 1'b0;
   end

   // ----------------------------------------------------------------
   // mirrored gauging status
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         bca_q <= 1'b0;
         sleep_q <= 1'b0;
         const_pwr_q <= 1'b0;
         rup_block_q <= 1'b0;
      end
      else
      begin
         bca_q <= BOARD_CAL_I;
         sleep_q <= SLEEP_I;
         const_pwr_q <= CONST_POWER_I;
         rup_block_q <= RES_UPD_BLOCK_I;
      end
   end

   // algorithm start raises both; unsuitable voltage drops only vok
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         vok_q <= 1'b0;
         qen_q <= 1'b0;
      end
      else if (go_q && code_q == SC_ALGO_START)
      begin
         vok_q <= 1'b1;
         qen_q <= 1'b1;
      end
      else if (VOLT_UNSUIT_I)
         vok_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // synchronisation tick
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         tick_cnt_q <= 28'h0000000;
         tick_q <= 1'b0;
      end
      else
      begin
         tick_q <= tick_cnt_q == TICK_LAST;
         tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 28'h0000000 : tick_cnt_q + 28'h0000001;
      end
   end

   // ----------------------------------------------------------------
   // rest-voltage sequencer
   // ----------------------------------------------------------------
   // a new request while one is pending is ignored rather than restarted
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         rv_state_q <= RV_IDLE;
         rv_cnt_q <= 26'h0000000;
         SOC_INT_O <= 1'b0;
         rv_done_q <= 1'b0;
         rv_fail_q <= 1'b0;
      end
      else
      begin
         unique case (rv_state_q)
            RV_IDLE:
               if (go_q && code_q == SC_REST_VOLT)
               begin
                  rv_done_q <= 1'b0;
                  rv_fail_q <= CHARGE_INHIBIT_FLAG_I && BATTERY_DETECTED_FLAG_O;
                  if (!CHARGE_INHIBIT_FLAG_I)
                     rv_state_q <= RV_WAIT_TICK;
               end
            RV_WAIT_TICK:
               if (tick_q)
               begin
                  rv_state_q <= RV_PULSE;
                  rv_cnt_q <= 26'h0000000;
                  SOC_INT_O <= 1'b1;
               end
            RV_PULSE:
               if (rv_cnt_q == RV_LAST)
               begin
                  rv_state_q <= RV_IDLE;
                  SOC_INT_O <= 1'b0;
                  rv_done_q <= BATTERY_DETECTED_FLAG_O;
                  rv_fail_q <= BATTERY_DETECTED_FLAG_O && RV_CUR_BAD_I;
               end
               else
                  rv_cnt_q <= rv_cnt_q + 26'h0000001;
            default:
               rv_state_q <= RV_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // counter calibration: first run after init, then on request
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS_I)
   begin
      if (RST_I)
      begin
         init_seen_q <= 1'b0;
         cca_armed_q <= 1'b0;
         cca_cnt_q <= 34'h000000000;
         cca_run_q <= 1'b0;
      end
      else if (cca_run_q)
      begin
         cca_run_q <= cca_cnt_q != CCA_RUN_LAST;
         cca_cnt_q <= cca_cnt_q + 34'h000000001;
      end
      else if (CAL_REQ_I || (cca_armed_q && cca_cnt_q == CCA_DELAY_LAST))
      begin
         cca_armed_q <= 1'b0;
         cca_run_q <= 1'b1;
         cca_cnt_q <= 34'h000000000;
      end
      else if (cca_armed_q)
         cca_cnt_q <= cca_cnt_q + 34'h000000001;
      else if (init_q && !init_seen_q)
      begin
         init_seen_q <= 1'b1;
         cca_armed_q <= 1'b1;
         cca_cnt_q <= 34'h000000000;
      end
   end

endmodule

// ---- bench/gcsu_properties.sv ----
// port checks for the gauge control subcommand unit
`timescale 1ns/1ps
module gcsu_props #(
   parameter longint unsigned RV_WIN_CYC_P = 20
)
(
   input wire logic CLK_SYS_I, // system clock
   input wire logic RST_I, // sync reset
   input wire logic INS_DET_EN_I, // detect enable
   input wire logic TS_PRESENT_I, // thermistor pin
   input wire logic SOC_INT_O, // window pulse
   input wire logic BATTERY_DETECTED_FLAG_O, // battery flag
   input wire logic DEEP_IDLE_REQ_O, // deep idle request
   input wire logic DEEP_IDLE_EXIT_O, // forced exit
   input wire logic RESTORE_O, // restore pulse
   input wire logic DEV_RESET_O, // reset pulse
   input wire logic ALGO_START_O, // algorithm start
   input wire logic SEALED_O // sealed
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   default disable iff (RST_I);
   logic [31:0] win_q;
   // window length so far, read on the falling edge
   always_ff @(posedge CLK_SYS_I)
   begin
      win_q <= (RST_I || !SOC_INT_O) ? 32'h0 : win_q + 32'h1;
   end
   // pin must settle through the two sync flops first
   sequence s_pin_on;
      (INS_DET_EN_I && TS_PRESENT_I)[*5];
   endsequence
   chk_restore_open: assert property (RESTORE_O |-> !SEALED_O)
      else $error("restore while sealed");
   chk_algo_open: assert property (ALGO_START_O |-> !SEALED_O)
      else $error("algorithm start while sealed");
   chk_reset_open: assert property (DEV_RESET_O |-> !SEALED_O)
      else $error("full reset while sealed");
   chk_seal_sticks: assert property (SEALED_O |=> SEALED_O)
      else $error("sealed state dropped");
   chk_exit_clears: assert property (DEEP_IDLE_EXIT_O |-> ##[0:1] !DEEP_IDLE_REQ_O)
      else $error("deep idle request kept on exit");
   chk_exit_single: assert property (DEEP_IDLE_EXIT_O |=> !DEEP_IDLE_EXIT_O)
      else $error("exit pulse too long");
   chk_win_len: assert property ($fell(SOC_INT_O) |-> win_q == 32'(RV_WIN_CYC_P))
      else $error("window length wrong");
   chk_det_follow: assert property (s_pin_on |-> BATTERY_DETECTED_FLAG_O)
      else $error("battery flag ignores pin");
endmodule
bind gcsu_top gcsu_props #(.RV_WIN_CYC_P(RV_WIN_CYC_P)) u_chk
(
   .CLK_SYS_I(CLK_SYS_I),
   .RST_I(RST_I),
   .INS_DET_EN_I(INS_DET_EN_I),
   .TS_PRESENT_I(TS_PRESENT_I),
   .SOC_INT_O(SOC_INT_O),
   .BATTERY_DETECTED_FLAG_O(BATTERY_DETECTED_FLAG_O),
   .DEEP_IDLE_REQ_O(DEEP_IDLE_REQ_O),
   .DEEP_IDLE_EXIT_O(DEEP_IDLE_EXIT_O),
   .RESTORE_O(RESTORE_O),
   .DEV_RESET_O(DEV_RESET_O),
   .ALGO_START_O(ALGO_START_O),
   .SEALED_O(SEALED_O)
);

// ---- bench/gcsu_host.sv ----
// host model writing and reading the command slot
`timescale 1ns/1ps
module gcsu_host (
   input wire logic link_clk_i, // link clock
   input wire logic [7:0] rdata_i, // read byte
   output logic wr_o, // write strobe
   output logic [7:0] addr_o, // command code
   output logic [7:0] wdata_o // write byte
);
   initial
   begin
      wr_o = 1'b0;
      addr_o = 8'h02;
      wdata_o = 8'h00;
   end
   // slot code then two bytes, low first; idle data inverted
   task automatic send(input logic [15:0] w);
      @(posedge link_clk_i) #1 {wr_o, addr_o, wdata_o} = {1'b1, 8'h00, w[7:0]};
      @(posedge link_clk_i) #1 {addr_o, wdata_o} = {8'h01, w[15:8]};
      @(posedge link_clk_i) #1 {wr_o, addr_o, wdata_o} = {1'b0, 8'h02, ~w[15:8]};
      repeat (4) @(posedge link_clk_i);
   endtask
   // answer needs the crossing handshake to refresh first
   task automatic read(output logic [15:0] w);
      repeat (20) @(posedge link_clk_i);
      #1 addr_o = 8'h00;
      @(posedge link_clk_i) #1 w[7:0] = rdata_i;
      addr_o = 8'h01;
      @(posedge link_clk_i) #1 w[15:8] = rdata_i;
      addr_o = 8'h02;
   endtask
endmodule

// ---- bench/testbench.sv ----
// self-checking bench for the gauge control subcommand unit
`timescale 1ns/1ps
module testbench;
   import gcsu_pkg::*;
   localparam int RV_WIN = 20;
   logic CLK_SYS_I = 0, RST_I = 1, LINK_CLK_I = 0, LNK_WR_I;
   logic [7:0] LNK_ADDR_I, LNK_WDATA_I, LNK_RDATA_O;
   logic INIT_DONE_I = 1, CHARGE_INHIBIT_FLAG_I = 0, RV_CUR_BAD_I = 0, INS_DET_EN_I = 0;
   logic TS_PRESENT_I = 0, SLEEP_I = 1, CONST_POWER_I = 1, RES_UPD_BLOCK_I = 0;
   logic DEEP_IDLE_EXIT_I = 0, VOLT_UNSUIT_I = 0, BOARD_CAL_I = 0, CAL_REQ_I = 0;
   logic SOC_INT_O, BATTERY_DETECTED_FLAG_O, DEEP_IDLE_REQ_O, DEEP_IDLE_EXIT_O, LIGHT_SLEEP_EN_O;
   logic RESTORE_O, DEV_RESET_O, ALGO_START_O, SEALED_O;
   int err_count = 0, checks_done = 0, soc_hi = 0, acts = 0;
   always #2 CLK_SYS_I = ~CLK_SYS_I;
   // link clock offset so its edges never line up with the system clock
   initial
   begin
      #1.7;
      forever #6 LINK_CLK_I = ~LINK_CLK_I;
   end
   always @(posedge CLK_SYS_I) soc_hi += (SOC_INT_O === 1'b1);
   // action pulses, one hex digit each: restore, full reset, algorithm start, exit
   always @(posedge CLK_SYS_I)
      acts += {RESTORE_O, 3'h0, DEV_RESET_O, 3'h0, ALGO_START_O, 3'h0, DEEP_IDLE_EXIT_O};
   // short counts keep the run small
   gcsu_top #(.TICK_CYC_P(100), .RV_WIN_CYC_P(RV_WIN), .CCA_DELAY_CYC_P(50),
      .CCA_RUN_CYC_P(10)) u_dut (.*);
   gcsu_host u_host (.link_clk_i(LINK_CLK_I), .rdata_i(LNK_RDATA_O), .wr_o(LNK_WR_I),
      .addr_o(LNK_ADDR_I), .wdata_o(LNK_WDATA_I));
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         err_count++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic ask(input logic [15:0] sc, input logic [15:0] exp);
      logic [15:0] r;
      u_host.send(sc);
      u_host.read(r);
      cmp(r, exp);
   endtask
   task automatic rv(input logic [15:0] exp, input int pulse);
      int b;
      b = soc_hi;
      u_host.send(SC_REST_VOLT);
      repeat (400) @(posedge CLK_SYS_I);
      cmp(16'(soc_hi - b), 16'(pulse));
      ask(SC_STATE, exp);
   endtask
   task automatic t_open();
      u_host.send(SC_FULL_RESET);
      u_host.send(SC_RESTORE);
      u_host.send(SC_ALGO_START);
      cmp(16'(acts), 16'h1110);
      ask(SC_STATE, 16'h001b);
      ask(SC_PART_TYPE, PART_TYPE_CODE);
      ask(SC_CODE_REV, CODE_REV_CODE);
      ask(SC_ECHO, SC_CODE_REV);
      ask(SC_CELL_PROFILE, CELL_PROFILE_CODE);
      ask(SC_ECHO, SC_CELL_PROFILE);
      ask(SC_CFG_REV, CFG_REV_CODE);
      $display("unsealed commands and queries done");
   endtask
   task automatic t_modes();
      u_host.send(SC_DEEP_IDLE_SET);
      cmp({15'h0, DEEP_IDLE_REQ_O}, 16'h1);
      // leaving deep idle must drop the request by itself
      @(posedge CLK_SYS_I) #1 DEEP_IDLE_EXIT_I = 1;
      @(posedge CLK_SYS_I) #1 DEEP_IDLE_EXIT_I = 0;
      cmp({15'h0, DEEP_IDLE_REQ_O}, 16'h0);
      u_host.send(SC_DEEP_IDLE_SET);
      ask(SC_ECHO, SC_ECHO);
      u_host.send(SC_DEEP_IDLE_CLR);
      cmp({15'h0, DEEP_IDLE_REQ_O}, 16'h0);
      cmp(16'(acts), 16'h1111);
      u_host.send(SC_LIGHT_SLEEP_SET);
      u_host.send(16'h0033);
      cmp({15'h0, LIGHT_SLEEP_EN_O}, 16'h1);
      u_host.send(SC_LIGHT_SLEEP_CLR);
      cmp({15'h0, LIGHT_SLEEP_EN_O}, 16'h0);
      $display("power mode requests done");
   endtask
   task automatic t_rest();
      u_host.send(SC_PACK_PRESENT);
      cmp({15'h0, BATTERY_DETECTED_FLAG_O}, 16'h1);
      rv(16'h029b, RV_WIN);
      @(posedge CLK_SYS_I) #1 RV_CUR_BAD_I = 1;
      rv(16'h039b, RV_WIN);
      @(posedge CLK_SYS_I) #1 CHARGE_INHIBIT_FLAG_I = 1;
      rv(16'h019b, 0);
      $display("rest voltage requests done");
   endtask
   task automatic t_seal();
      u_host.send(SC_SEAL);
      ask(SC_STATE, 16'h619b);
      u_host.send(SC_RESTORE);
      u_host.send(SC_ALGO_START);
      u_host.send(SC_FULL_RESET);
      cmp({15'h0, SEALED_O}, 16'h1);
      cmp(16'(acts), 16'h1111);
      ask(SC_ECHO, SC_STATE);
      u_host.send(SC_PACK_ABSENT);
      cmp({15'h0, BATTERY_DETECTED_FLAG_O}, 16'h0);
      @(posedge CLK_SYS_I) #1 {INS_DET_EN_I, TS_PRESENT_I} = 2'b11;
      repeat (10) @(posedge CLK_SYS_I);
      cmp({15'h0, BATTERY_DETECTED_FLAG_O}, 16'h1);
      $display("sealed behaviour and detection done");
   endtask
   task automatic give_verdict();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge CLK_SYS_I);
      #1 RST_I = 0;
      repeat (20) @(posedge CLK_SYS_I);
      t_open();
      t_modes();
      t_rest();
      t_seal();
      give_verdict();
   end
endmodule
